// [include/crx_consts.svh]
// Constants of the receive mailbox block: register offsets, field positions, codes, sizes.
// Assumes byte addressing over APB with one aligned 32-bit word per register.
`ifndef CRX_CONSTS_SVH
`define CRX_CONSTS_SVH

// Sizes
`define CRX_NMB         4
`define CRX_FIFO_DEPTH  4

// Register byte offsets
`define CRX_A_MCR       8'h00
`define CRX_A_EFCR      8'h04
`define CRX_A_TIMER     8'h08
`define CRX_A_FLAGS     8'h0C
`define CRX_A_FIFO_ID   8'h10
`define CRX_A_FIFO_DATA 8'h14
`define CRX_A_STAT      8'h18
`define CRX_MB_REGION   2'h1
`define CRX_MB_W_CS     2'h0
`define CRX_MB_W_ID     2'h1
`define CRX_MB_W_DATA   2'h2

// Field positions
`define CRX_MCR_LFEN    0
`define CRX_EFCR_EFEN   0
`define CRX_CS_CODE_LSB 24
`define CRX_CS_BUSY     20
`define CRX_ST_LOST     0
`define CRX_ST_LOCKV    1
`define CRX_ST_EMPTY    2
`define CRX_ST_FULL     3
`define CRX_ST_LOCKI    4

// Mailbox codes
`define CRX_CODE_INACTIVE 4'h0
`define CRX_CODE_EMPTY    4'h4
`define CRX_CODE_FULL     4'h2
`define CRX_CODE_OVERRUN  4'h6

// Reset values
`define CRX_ZERO32      32'h0000_0000

`endif

// [include/crx_pkg.sv]
// Types of the receive mailbox block: frame carrier, mailbox record, engine states.
// Assumes crx_consts.svh is on the include path.
`include "crx_consts.svh"

package crx_pkg;

  // One received frame as handed over by the protocol engine
  typedef struct packed {
    logic [10:0] id;
    logic [31:0] data;
  } crx_frame_t;

  // Frame plus its arrival time as held inside the block
  typedef struct packed {
    logic [10:0] id;
    logic [31:0] data;
    logic [15:0] stamp;
  } crx_held_t;

  // One receive mailbox
  typedef struct packed {
    logic [3:0]  code;
    logic [10:0] filt;
    logic [31:0] data;
    logic [15:0] stamp;
  } crx_mb_t;

  // Transfer engine states
  typedef enum logic [0:0] {
    CRX_MV_IDLE,
    CRX_MV_WRITE
  } crx_mv_t;

endpackage

// [hw/crx_mailbox_lock.sv]
// Receive path of a CAN controller: two holding buffers, dedicated mailboxes with
// software locking, a receive FIFO (legacy or enhanced) and the APB register slave.
// Assumes frames arrive as one-cycle strobes from a protocol engine on pclk.
`timescale 1ns/1ps

// Summary of operation
// - Matching frame moves from holding buffer to mailbox
// - Locked destination: frame waits in first buffer
// - Next frame loads into second buffer meanwhile
// - After unlock, transfer with correct full code
// - Each frame routed to mailbox, else FIFO if enabled, else discarded
// - Legacy FIFO only when its enable set
// - Enhanced FIFO only when its enable set
// - Control word shows busy while being updated
// - Timer read releases any mailbox lock
module crx_mailbox_lock
  import crx_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Frames from the protocol engine
  input  wire logic               rx_valid,
  input  wire crx_pkg::crx_frame_t rx_frame
);
  import crx_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    crx_mb_t [`CRX_NMB-1:0]        mb;        // Mailboxes
    crx_held_t [`CRX_FIFO_DEPTH-1:0] fifo;    // FIFO storage
    logic [2:0]                    wp;        // FIFO write pointer, wrap bit on top
    logic [2:0]                    rp;        // FIFO read pointer
    crx_held_t                     h0;        // First holding buffer
    logic                          h0_v;
    crx_held_t                     h1;        // Second holding buffer
    logic                          h1_v;
    crx_mv_t                       mv;        // Transfer engine state
    logic [1:0]                    mv_idx;    // Mailbox being written
    logic                          lock_v;    // A mailbox is locked
    logic [1:0]                    lock_idx;  // Which one
    logic [`CRX_NMB-1:0]           flags;     // Mailbox event flags
    logic                          lfen;      // Legacy FIFO enable
    logic                          efen;      // Enhanced FIFO enable
    logic                          lost;      // Frame dropped, sticky
    logic [15:0]                   timer;     // Free-running timer
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
  } crx_state_t;

  crx_state_t s_r;    // Registered state
  crx_state_t s_nxt;  // Next state

  // Mailbox region decode, used for reads and for side effects alike
  function automatic logic mb_hit(input logic [7:0] a);
    mb_hit = (a[7:6] == `CRX_MB_REGION) && (a[3:2] != 2'h3);
  endfunction

  // Scratch values of the next-state process
  logic        acc;       // First access cycle, answer being prepared
  logic        done;      // Completing edge of a transfer
  logic        fifo_on;   // Some FIFO is enabled
  logic        fifo_full;
  logic        fifo_empty;
  logic        hit;
  logic [1:0]  hit_idx;
  logic        rel;       // First holding buffer is released this cycle
  logic [1:0]  ai;        // Mailbox index from the address
  logic [31:0] rd;
  logic        err;
  logic        lost_set;  // A frame is dropped this cycle; beats a clear
  logic [`CRX_NMB-1:0] flag_set;  // Event flags raised this cycle; beat a clear

  // Next-state logic
  always_comb begin
    s_nxt      = s_r;
    acc        = psel && penable && !s_r.pready;
    done       = psel && penable && s_r.pready;
    ai         = paddr[5:4];
    fifo_on    = s_r.lfen || s_r.efen;
    fifo_empty = (s_r.wp == s_r.rp);
    fifo_full  = (s_r.wp[1:0] == s_r.rp[1:0]) && (s_r.wp[2] != s_r.rp[2]);
    hit        = 1'b0;
    hit_idx    = 2'h0;
    rel        = 1'b0;
    rd         = `CRX_ZERO32;
    err        = 1'b0;
    lost_set   = 1'b0;
    flag_set   = '0;

    // Free-running timer
    s_nxt.timer = s_r.timer + 16'h0001;

    // Search active receive mailboxes for the pending frame; the lowest matching index wins
    for (int i = `CRX_NMB - 1; i >= 0; i--) begin
      if ((s_r.mb[i].code == `CRX_CODE_EMPTY || s_r.mb[i].code == `CRX_CODE_FULL ||
           s_r.mb[i].code == `CRX_CODE_OVERRUN) && s_r.mb[i].filt == s_r.h0.id) begin
        hit     = 1'b1;
        hit_idx = 2'(i);
      end
    end

    // Transfer engine
    case (s_r.mv)
      CRX_MV_IDLE: begin
        if (s_r.h0_v) begin
          if (hit) begin
            // Locked destination keeps the frame in the first buffer
            if (!(s_r.lock_v && s_r.lock_idx == hit_idx)) begin
              s_nxt.mv     = CRX_MV_WRITE;
              s_nxt.mv_idx = hit_idx;
            end
          end else if (fifo_on) begin
            // No mailbox wants it: the FIFO takes it, or it is lost when full
            if (!fifo_full) begin
              s_nxt.fifo[s_r.wp[1:0]] = s_r.h0;
              s_nxt.wp = s_r.wp + 3'h1;
            end else begin
              s_nxt.lost = 1'b1;
              lost_set   = 1'b1;
            end
            rel = 1'b1;
          end else begin
            // Without a FIFO an unmatched frame is discarded
            rel = 1'b1;
          end
        end
      end
      CRX_MV_WRITE: begin
        s_nxt.mv = CRX_MV_IDLE;
        // A lock taken during the decision cycle still defers the write
        if (!(s_r.lock_v && s_r.lock_idx == s_r.mv_idx)) begin
          // Code always derives from the mailbox's own state, never from stale data
          s_nxt.mb[s_r.mv_idx].code  = (s_r.mb[s_r.mv_idx].code == `CRX_CODE_EMPTY) ?
                                       `CRX_CODE_FULL : `CRX_CODE_OVERRUN;
          s_nxt.mb[s_r.mv_idx].data  = s_r.h0.data;
          s_nxt.mb[s_r.mv_idx].stamp = s_r.h0.stamp;
          s_nxt.flags[s_r.mv_idx]    = 1'b1;
          flag_set[s_r.mv_idx]       = 1'b1;
          rel = 1'b1;
        end
      end
      default: s_nxt.mv = CRX_MV_IDLE;
    endcase

    // Shift the second buffer forward when the first one empties
    if (rel) begin
      s_nxt.h0   = s_r.h1;
      s_nxt.h0_v = s_r.h1_v;
      s_nxt.h1_v = 1'b0;
    end

    // Load an arriving frame into the first free buffer
    if (rx_valid) begin
      if (!s_nxt.h0_v) begin
        s_nxt.h0   = '{id: rx_frame.id, data: rx_frame.data, stamp: s_r.timer};
        s_nxt.h0_v = 1'b1;
      end else if (!s_nxt.h1_v) begin
        s_nxt.h1   = '{id: rx_frame.id, data: rx_frame.data, stamp: s_r.timer};
        s_nxt.h1_v = 1'b1;
      end else begin
        // Both buffers full: the frame is dropped and recorded
        s_nxt.lost = 1'b1;
        lost_set   = 1'b1;
      end
    end

    // Read data and error, prepared in the first access cycle
    if (paddr == `CRX_A_MCR) begin
      rd[`CRX_MCR_LFEN] = s_r.lfen;
    end else if (paddr == `CRX_A_EFCR) begin
      rd[`CRX_EFCR_EFEN] = s_r.efen;
    end else if (paddr == `CRX_A_TIMER) begin
      rd[15:0] = s_r.timer;
    end else if (paddr == `CRX_A_FLAGS) begin
      rd[`CRX_NMB-1:0] = s_r.flags;
    end else if (paddr == `CRX_A_FIFO_ID) begin
      rd[26:16] = s_r.fifo[s_r.rp[1:0]].id;
      rd[15:0]  = s_r.fifo[s_r.rp[1:0]].stamp;
    end else if (paddr == `CRX_A_FIFO_DATA) begin
      rd = s_r.fifo[s_r.rp[1:0]].data;
    end else if (paddr == `CRX_A_STAT) begin
      rd[`CRX_ST_LOST]            = s_r.lost;
      rd[`CRX_ST_LOCKV]           = s_r.lock_v;
      rd[`CRX_ST_EMPTY]           = fifo_empty;
      rd[`CRX_ST_FULL]            = fifo_full;
      rd[`CRX_ST_LOCKI+1:`CRX_ST_LOCKI] = s_r.lock_idx;
    end else if (mb_hit(paddr) && paddr[3:2] == `CRX_MB_W_CS) begin
      rd[`CRX_CS_CODE_LSB+3:`CRX_CS_CODE_LSB] = s_r.mb[ai].code;
      rd[`CRX_CS_BUSY] = (s_r.mv == CRX_MV_WRITE) && (s_r.mv_idx == ai);
      rd[15:0] = s_r.mb[ai].stamp;
    end else if (mb_hit(paddr) && paddr[3:2] == `CRX_MB_W_ID) begin
      rd[10:0] = s_r.mb[ai].filt;
    end else if (mb_hit(paddr)) begin
      rd = s_r.mb[ai].data;
    end else begin
      err = 1'b1;
    end

    // One wait state: answer prepared, then completed
    s_nxt.pready = acc;
    if (acc) begin
      s_nxt.prdata  = pwrite ? `CRX_ZERO32 : (err ? `CRX_ZERO32 : rd);
      s_nxt.pslverr = err;
    end else if (done) begin
      s_nxt.pslverr = 1'b0;
    end

    // Side effects take place at the completing edge only
    if (done && !err) begin
      if (pwrite) begin
        if (paddr == `CRX_A_MCR) begin
          s_nxt.lfen = pwdata[`CRX_MCR_LFEN];
        end else if (paddr == `CRX_A_EFCR) begin
          s_nxt.efen = pwdata[`CRX_EFCR_EFEN];
        end else if (paddr == `CRX_A_FLAGS) begin
          // Write one to clear; a flag set in the same cycle survives
          s_nxt.flags = (s_r.flags & ~pwdata[`CRX_NMB-1:0]) | flag_set;
        end else if (paddr == `CRX_A_STAT) begin
          // A drop in the clearing cycle keeps the sticky bit set
          s_nxt.lost = (s_r.lost & ~pwdata[`CRX_ST_LOST]) | lost_set;
        end else if (mb_hit(paddr) && paddr[3:2] == `CRX_MB_W_CS) begin
          s_nxt.mb[ai].code = pwdata[`CRX_CS_CODE_LSB+3:`CRX_CS_CODE_LSB];
        end else if (mb_hit(paddr) && paddr[3:2] == `CRX_MB_W_ID) begin
          s_nxt.mb[ai].filt = pwdata[10:0];
        end else if (mb_hit(paddr)) begin
          s_nxt.mb[ai].data = pwdata;
        end
      end else begin
        if (paddr == `CRX_A_TIMER) begin
          s_nxt.lock_v = 1'b0;
        end else if (paddr == `CRX_A_FIFO_DATA && !fifo_empty) begin
          s_nxt.rp = s_r.rp + 3'h1;
        end else if (mb_hit(paddr) && paddr[3:2] == `CRX_MB_W_CS) begin
          // Locking a new mailbox drops the lock of the previous one
          s_nxt.lock_v   = 1'b1;
          s_nxt.lock_idx = ai;
        end
      end
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;

endmodule

// [test/crx_node_model.sv]
// Model of the other CAN nodes, seen through the protocol engine.
// Assumes frames reach the block as one-cycle strobes on pclk.
`timescale 1ns/1ps
module crx_node_model (
  // Clock
  input  wire logic           pclk,
  // Frame strobe towards the block
  output logic                rx_valid,
  output crx_pkg::crx_frame_t rx_frame
);
  import crx_pkg::*;
  // Line quiet at start
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // One frame; afterwards the bits show the inverse so stale data never matches
  task automatic send(input logic [10:0] id, input logic [31:0] data);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= {id, data};
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~{id, data};
  endtask
endmodule

// [test/crx_mailbox_lock_chk.sv]
// Checker of the receive mailbox block, bound to its top module.
// Assumes one APB wait state and the block's register map.
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_mailbox_lock_chk (
  // Clock and control
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       done, rd;              // Completed transfer, completed read
  logic       lf_r, ef_r, lk_r;      // Shadow enables and lock
  logic [1:0] li_r;                  // Shadow lock index
  assign done = psel && penable && pready && clk_en;
  assign rd   = done && !pwrite;
  // Shadow state, updated at the edge where the block commits a transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lf_r, ef_r, lk_r, li_r} <= '0;
    end else if (done && !pslverr) begin
      if (pwrite && paddr == `CRX_A_MCR) begin
        lf_r <= pwdata[0];
      end
      if (pwrite && paddr == `CRX_A_EFCR) begin
        ef_r <= pwdata[0];
      end
      // Control word read takes the lock; timer read drops it
      if (!pwrite && paddr[7:6] == `CRX_MB_REGION && paddr[3:2] == `CRX_MB_W_CS) begin
        lk_r <= 1'b1;
        li_r <= paddr[5:4];
      end else if (!pwrite && paddr == `CRX_A_TIMER) begin
        lk_r <= 1'b0;
      end
    end
  end
  property p_rdy; psel && penable && !pready && clk_en |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after access");
  property p_one; pready && clk_en |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_unm; done && paddr[7:6] == 2'h1 && paddr[3:2] == 2'h3 |-> pslverr && prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped word accepted");
  property p_lf; rd && paddr == `CRX_A_MCR |-> prdata == {31'h0, lf_r}; endproperty
  a_lf: assert property (p_lf) else $error("legacy enable readback wrong");
  property p_ef; rd && paddr == `CRX_A_EFCR |-> prdata == {31'h0, ef_r}; endproperty
  a_ef: assert property (p_ef) else $error("enhanced enable readback wrong");
  property p_lk; rd && paddr == `CRX_A_STAT |-> prdata[1] == lk_r && (!lk_r || prdata[5:4] == li_r); endproperty
  a_lk: assert property (p_lk) else $error("lock state wrong");
  // Four cycles reach a status read that follows after one idle edge
  property p_ul; rd && paddr == `CRX_A_TIMER |=> (!(rd && paddr == `CRX_A_STAT && prdata[1]))[*4]; endproperty
  a_ul: assert property (p_ul) else $error("lock kept after timer read");
  property p_st; rd && paddr == `CRX_A_STAT |-> !(prdata[2] && prdata[3]); endproperty
  a_st: assert property (p_st) else $error("queue empty and full at once");
endmodule
bind crx_mailbox_lock crx_mailbox_lock_chk chk_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr);

// [test/crx_mailbox_lock_tb.sv]
// Testbench of the receive mailbox block: APB tasks and checked reads.
// Assumes the node model sends frames and the checker is bound.
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_mailbox_lock_tb;
  import crx_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF; // Full compare mask
  localparam logic [31:0] CS  = 32'h0F10_0000; // Code and busy field
  logic        pclk, presetn, clk_en;          // Clock, reset, enable
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rx_valid;                       // Frame strobe
  crx_frame_t  rx_frame;
  int          failures, checked;              // Mismatches, comparisons
  crx_mailbox_lock dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_valid, .rx_frame);
  crx_node_model node_u (.pclk, .rx_valid, .rx_frame);
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Masked compare of one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checked++;
    if ((got & msk) !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got & msk, exp);
    end
  endtask
  // One APB transfer; an idle edge before setup avoids driving twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msk);
  endtask
  // Frame, then time for load and mailbox write
  task automatic frame(input logic [10:0] id, input logic [31:0] d);
    node_u.send(id, d);
    repeat (6) @(posedge pclk);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en  = 1'b1;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`CRX_A_MCR, 32'h0, ALL);
    rdc(`CRX_A_STAT, 32'h4, 32'h3F);
    apb(1'b1, 8'h44, 32'h123);
    apb(1'b1, 8'h54, 32'h055);
    apb(1'b1, 8'h40, 32'h0400_0000);
    apb(1'b1, 8'h50, 32'h0400_0000);
    // Plain delivery and service sequence
    frame(11'h123, 32'hA5A5_0001);
    rdc(8'h40, 32'h0200_0000, CS);
    rdc(8'h48, 32'hA5A5_0001, ALL);
    rdc(`CRX_A_FLAGS, 32'h1, 32'hF);
    apb(1'b1, `CRX_A_FLAGS, 32'h1);
    rdc(`CRX_A_STAT, 32'h6, 32'h3F);
    apb(1'b0, `CRX_A_TIMER, 32'h0);
    rdc(`CRX_A_STAT, 32'h4, 32'h3F);
    // Locked destination with a queue frame behind it
    apb(1'b1, `CRX_A_MCR, 32'h1);
    apb(1'b1, 8'h40, 32'h0400_0000);
    rdc(8'h40, 32'h0400_0000, CS);
    node_u.send(11'h123, 32'hB0B0_0002);
    frame(11'h3FF, 32'hC0C0_0003);
    rdc(8'h48, 32'hA5A5_0001, ALL);
    rdc(`CRX_A_STAT, 32'h6, 32'h3F);
    rdc(8'h50, 32'h0400_0000, CS);
    repeat (6) @(posedge pclk);
    rdc(`CRX_A_STAT, 32'h12, 32'h3F);
    apb(1'b0, `CRX_A_TIMER, 32'h0);
    rdc(8'h40, 32'h0200_0000, CS);
    rdc(8'h48, 32'hB0B0_0002, ALL);
    rdc(`CRX_A_FIFO_ID, 32'h03FF_0000, 32'h07FF_0000);
    rdc(`CRX_A_FIFO_DATA, 32'hC0C0_0003, ALL);
    apb(1'b0, `CRX_A_TIMER, 32'h0);
    // Enhanced queue, then both off
    apb(1'b1, `CRX_A_MCR, 32'h0);
    apb(1'b1, `CRX_A_EFCR, 32'h1);
    frame(11'h2AA, 32'hD0D0_0004);
    rdc(`CRX_A_FIFO_DATA, 32'hD0D0_0004, ALL);
    apb(1'b1, `CRX_A_EFCR, 32'h0);
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    clk_en <= 1'b1;
    frame(11'h2AA, 32'hE0E0_0005);
    rdc(`CRX_A_STAT, 32'h4, 32'h3F);
    // Control word read whose first access edge meets the mailbox write shows busy
    fork
      node_u.send(11'h055, 32'hF0F0_0006);
      begin
        @(posedge pclk);
        rdc(8'h50, 32'h0410_0000, CS);
      end
    join
    rdc(8'h58, 32'hF0F0_0006, ALL);
    apb(1'b0, `CRX_A_TIMER, 32'h0);
    // Three frames for a locked mailbox: one waits, one is held, one is lost
    rdc(8'h40, 32'h0200_0000, CS);
    node_u.send(11'h123, 32'h1111_0007);
    node_u.send(11'h123, 32'h1111_0008);
    frame(11'h123, 32'h1111_0009);
    rdc(`CRX_A_STAT, 32'h7, 32'h3F);
    apb(1'b0, `CRX_A_TIMER, 32'h0);
    repeat (6) @(posedge pclk);
    rdc(8'h40, 32'h0600_0000, CS);
    rdc(8'h48, 32'h1111_0008, ALL);
    apb(1'b1, `CRX_A_STAT, 32'h1);
    rdc(`CRX_A_STAT, 32'h6, 32'h3F);
    apb(1'b0, `CRX_A_TIMER, 32'h0);
    // Unmapped mailbox word
    rdc(8'h4C, 32'h0, ALL);
    chk({31'h0, err}, 32'h1, ALL);
    finish_test;
  end
endmodule
